// >>> wdpic_regs.svh
// Register indices, field positions, reset values and timing counts of the supervision block.
// Assumes a 40 MHz system clock; byte address of a register is four times its index.
`ifndef WDPIC_REGS_SVH
`define WDPIC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define WDPIC_IDX_PIC_CTRL 8'h14
`define WDPIC_IDX_PIC_FLAG 8'h15
`define WDPIC_IDX_WD_CTRL  8'h16
`define WDPIC_IDX_WD_SVC   8'h17
`define WDPIC_IDX_INT_CTRL 8'h1e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDPIC_PC_IRQ_EN 7
`define WDPIC_PC_WAIT   6
`define WDPIC_PC_DEBUG  5
`define WDPIC_PC_BYP    3
`define WDPIC_PF_FLAG   7
`define WDPIC_WC_CME    7
`define WDPIC_IC_DLY    5

// ----------------------------------------------------------------
// Reset values and service codes
// ----------------------------------------------------------------
`define WDPIC_PIC_RATE_RST 3'h0
`define WDPIC_WD_RATE_RST  3'h1
`define WDPIC_DLY_RST      1'b1
`define WDPIC_SVC_ARM      8'h55
`define WDPIC_SVC_FIRE     8'haa

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDPIC_CLK_NS       25
`define WDPIC_CM_WINDOW_NS 20000
`define WDPIC_CM_CYCLES    (`WDPIC_CM_WINDOW_NS / `WDPIC_CLK_NS)
`define WDPIC_PIC_EXP_BASE 5'd12
`define WDPIC_BYP_DROP     5'd11

`endif

// >>> wdpic_pkg.sv
// Types shared by the supervision block: service sequence states and the watchdog rate table.
// Assumes wdpic_regs.svh is on the include path.
package wdpic_pkg;

	// One-hot states of the two-step service sequence.
	typedef enum logic [2:0] {
		WDPIC_SVC_IDLE  = 3'b001,
		WDPIC_SVC_ARMED = 3'b010,
		WDPIC_SVC_FAULT = 3'b100
	} wdpic_svc_e;

	typedef logic [7:0] wdpic_byte_t;

	// Watchdog divide exponent per rate code; code 0 is off and returns 0.
	function automatic logic [4:0] wdpic_wd_exp(input logic [2:0] rate);
		case (rate)
			3'h1: wdpic_wd_exp = 5'd13;
			3'h2: wdpic_wd_exp = 5'd15;
			3'h3: wdpic_wd_exp = 5'd17;
			3'h4: wdpic_wd_exp = 5'd19;
			3'h5: wdpic_wd_exp = 5'd21;
			3'h6: wdpic_wd_exp = 5'd22;
			3'h7: wdpic_wd_exp = 5'd23;
			default: wdpic_wd_exp = 5'd0;
		endcase
	endfunction

endpackage

// >>> wdpic_tick_if.sv
// Carrier between the top and its peripheral clock divider.
// Assumes both ends run on sys_clk.
interface wdpic_tick_if;
	logic run;
	logic tick;
	modport src (input run, output tick);
	modport dst (output run, input tick);
endinterface

// >>> wdpic_tick_div.sv
// Peripheral clock enable divider: one-cycle tick every DIV system clocks while running.
// Assumes a single clock; the halted state simply freezes the divider phase.
module wdpic_tick_div #(
	parameter int DIV = 2
) (
	input  wire logic sys_clk,
	input  wire logic resetn,
	wdpic_tick_if.src tk
);
	logic [15:0] cnt;

	// Counting stops while halted so both counters behind it freeze together.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 16'h0000;
			tk.tick <= 1'b0;
		end else if (!tk.run) begin
			tk.tick <= 1'b0;
		end else if (cnt == 16'(DIV - 1)) begin
			cnt <= 16'h0000;
			tk.tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tk.tick <= 1'b0;
		end
	end
endmodule

// >>> wdpic_sync3.sv
// Three-stage synchroniser with agreement filter for a pin from outside the clock domain.
// Assumes the pin is slow compared with sys_clk.
module wdpic_sync3 (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic s1;
	logic s2;
	logic s3;

	// The level changes only once stages two and three agree.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q  <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule

// >>> wdpic_top.sv
// Watchdog, periodic interrupt and clock-loss monitor behind an AHB-Lite register slave.
// Assumes mode inputs come from logic on sys_clk and the monitored clock arrives on a pin.
// Function
// - Reset leaves the watchdog enabled with the shortest time-out code.
// - Reset leaves the clock-loss monitor disabled.
// - Reset clears the periodic flag and masks its interrupt.
// - Reset clears the periodic rate, so the periodic flag is not set until a nonzero rate is written.
// - Reset sets the stop-exit delay bit.
// - Watchdog and periodic counters advance on the peripheral clock enable.
// - Enabled watchdog reaching its period without service requests a system reset.
// - Three-bit watchdog rate gives seven periods; the remaining code disables it.
// - Any other value written to the service register resets at once.
// - Periodic interrupt has seven rates from a three-bit field, a flag, an enable.
// - Enabled monitor resets the system when no clock edge arrives in its window.
// - With enable set, interrupt request stands while the periodic flag is set.
// - Wait-halt bit set stops both counters during wait mode.
// - Debug-halt bit set stops both counters during debug mode.
// - Halt bits are write-once in normal modes, free in special modes.
// - Periodic rate 0 is off; codes 1 to 7 divide by 2^13 to 2^19.
// - Watchdog rate 0 is off; codes divide by 2^13,15,17,19,21,22,23.
// - Writing one to the flag bit clears it; writing zero leaves it.
// - Enabled monitor also fails on clocks stopped by stop mode.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "wdpic_regs.svh"

module wdpic_top
	import wdpic_pkg::*;
#(
	parameter int PCLK_DIV = 2,
	parameter int DIV_TRIM = 0
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        wait_mode,
	input  wire logic        debug_mode,
	input  wire logic        stop_mode,
	input  wire logic        special_mode,
	input  wire logic        mon_clk_pin,
	output logic             periodic_irq,
	output logic             wdog_reset_req,
	output logic             clk_fail_reset_req,
	output logic             stop_exit_delay
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic        wr_pend;
	logic        rd_pend;
	logic [7:0]  wr_idx;
	logic [7:0]  rd_idx;
	wdpic_byte_t wr_byte;
	wdpic_byte_t rd_mux;
	logic        wr_go;
	logic        periodic_irq_en;
	logic        wait_halt_bit;
	logic        debug_halt_bit;
	logic        divider_bypass;
	logic [2:0]  periodic_rate_sel;
	logic        periodic_flag;
	logic        clk_loss_mon_en;
	logic [2:0]  wdog_rate_sel;
	logic        halt_lock;
	logic        rate_lock;
	logic        dly_lock;
	wdpic_svc_e  svc_st;
	logic        svc_wr;
	logic [18:0] pic_cnt;
	logic [18:0] pic_mask;
	logic [4:0]  pic_exp;
	logic        pic_hit;
	logic [22:0] wd_cnt;
	logic [22:0] wd_lim;
	logic [4:0]  wd_exp;
	logic        wd_hit;
	logic        wd_restart;
	logic        p_tick;
	logic        mon_lvl;
	logic        mon_lvl_d;
	logic [11:0] cm_cnt;
	logic        cm_fail;

	wdpic_tick_if tk ();

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------

	// Writes finish with no wait state; reads take one wait so a read right
	// after a write still returns the freshly written value.
	assign hreadyout = !rd_pend;
	assign hresp     = 1'b0;
	assign wr_go     = wr_pend;
	assign wr_byte   = hwdata[7:0];

	// Address phase capture.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_idx  <= 8'h00;
			rd_idx  <= 8'h00;
		end else begin
			if (hready) begin
				wr_pend <= hsel && htrans[1] && hwrite;
				rd_pend <= hsel && htrans[1] && !hwrite;
				wr_idx  <= haddr[9:2];
				rd_idx  <= haddr[9:2];
			end else begin
				rd_pend <= 1'b0;
			end
		end
	end

	// Read data multiplexer; unmapped indices and reserved bits read zero.
	always_comb begin
		rd_mux = 8'h00;
		case (rd_idx)
			`WDPIC_IDX_PIC_CTRL: rd_mux = {periodic_irq_en, wait_halt_bit, debug_halt_bit,
				1'b0, divider_bypass, periodic_rate_sel};
			`WDPIC_IDX_PIC_FLAG: rd_mux = {periodic_flag, 7'h00};
			`WDPIC_IDX_WD_CTRL:  rd_mux = {clk_loss_mon_en, 4'h0, wdog_rate_sel};
			`WDPIC_IDX_INT_CTRL: rd_mux = {2'h0, stop_exit_delay, 5'h00};
			default:             rd_mux = 8'h00;
		endcase
	end

	// Read data is registered during the wait cycle.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			hrdata <= 32'h0000_0000;
		else if (rd_pend)
			hrdata <= {24'h00_0000, rd_mux};
	end

	// ----------------------------------------------------------------
	// Periodic control register
	// ----------------------------------------------------------------

	// Enable and rate are free; halt bits lock after the first normal-mode write.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			periodic_irq_en   <= 1'b0;
			wait_halt_bit     <= 1'b0;
			debug_halt_bit    <= 1'b0;
			divider_bypass    <= 1'b0;
			periodic_rate_sel <= `WDPIC_PIC_RATE_RST;
			halt_lock         <= 1'b0;
		end else if (wr_go && wr_idx == `WDPIC_IDX_PIC_CTRL) begin
			periodic_irq_en   <= wr_byte[`WDPIC_PC_IRQ_EN];
			periodic_rate_sel <= wr_byte[2:0];
			if (special_mode || !halt_lock) begin
				wait_halt_bit  <= wr_byte[`WDPIC_PC_WAIT];
				debug_halt_bit <= wr_byte[`WDPIC_PC_DEBUG];
			end
			if (!special_mode)
				halt_lock <= 1'b1;
			if (special_mode)
				divider_bypass <= wr_byte[`WDPIC_PC_BYP];
		end
	end

	// ----------------------------------------------------------------
	// Watchdog control and stop-exit delay
	// ----------------------------------------------------------------

	// Rate is write-once in normal modes so runaway code cannot switch it off.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_loss_mon_en <= 1'b0;
			wdog_rate_sel   <= `WDPIC_WD_RATE_RST;
			rate_lock       <= 1'b0;
		end else if (wr_go && wr_idx == `WDPIC_IDX_WD_CTRL) begin
			clk_loss_mon_en <= wr_byte[`WDPIC_WC_CME];
			if (special_mode || !rate_lock)
				wdog_rate_sel <= wr_byte[2:0];
			if (!special_mode)
				rate_lock <= 1'b1;
		end
	end

	// Stop-exit delay bit, also write-once in normal modes.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stop_exit_delay <= `WDPIC_DLY_RST;
			dly_lock        <= 1'b0;
		end else if (wr_go && wr_idx == `WDPIC_IDX_INT_CTRL) begin
			if (special_mode || !dly_lock)
				stop_exit_delay <= wr_byte[`WDPIC_IC_DLY];
			if (!special_mode)
				dly_lock <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral clock enable and halting
	// ----------------------------------------------------------------

	// Either halt condition freezes the shared divider, stopping both counters.
	assign tk.run = !(wait_mode && wait_halt_bit) && !(debug_mode && debug_halt_bit);
	assign p_tick = tk.tick;

	wdpic_tick_div #(
		.DIV (PCLK_DIV)
	) u_div (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.tk      (tk.src)
	);

	// ----------------------------------------------------------------
	// Periodic interrupt
	// ----------------------------------------------------------------

	// Bypass drops eleven stages so tests need not wait 2^13 ticks.
	assign pic_exp  = divider_bypass ? `WDPIC_PIC_EXP_BASE + 5'(periodic_rate_sel)
		- `WDPIC_BYP_DROP : `WDPIC_PIC_EXP_BASE + 5'(periodic_rate_sel) - 5'(DIV_TRIM);
	assign pic_mask = (19'h0_0001 << pic_exp) - 19'h0_0001;
	assign pic_hit  = p_tick && periodic_rate_sel != 3'h0 && (pic_cnt & pic_mask) == pic_mask;

	// Free-running divider chain on the peripheral tick.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			pic_cnt <= 19'h0_0000;
		else if (p_tick)
			pic_cnt <= pic_cnt + 19'h0_0001;
	end

	// Sticky flag; a period reached in the clearing cycle still sets it.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			periodic_flag <= 1'b0;
		else if (pic_hit)
			periodic_flag <= 1'b1;
		else if (wr_go && wr_idx == `WDPIC_IDX_PIC_FLAG && wr_byte[`WDPIC_PF_FLAG])
			periodic_flag <= 1'b0;
	end

	assign periodic_irq = periodic_flag && periodic_irq_en;

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------

	// Rate code 0 gives exponent 0; the wdog_rate_sel check in wd_hit and the counter clear keep the watchdog off.
	assign wd_exp = wdpic_wd_exp(wdog_rate_sel);
	assign wd_lim = (23'h00_0001 << (divider_bypass ? wd_exp - `WDPIC_BYP_DROP
		: wd_exp - 5'(DIV_TRIM))) - 23'h00_0001;
	assign wd_hit = p_tick && wdog_rate_sel != 3'h0 && wd_cnt == wd_lim;
	assign svc_wr = wr_go && wr_idx == `WDPIC_IDX_WD_SVC;
	assign wd_restart = svc_wr && svc_st == WDPIC_SVC_ARMED && wr_byte == `WDPIC_SVC_FIRE;

	// Service sequence; writes between the two steps elsewhere are harmless.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			svc_st <= WDPIC_SVC_IDLE;
		else if (svc_wr) begin
			if (wr_byte == `WDPIC_SVC_ARM)
				svc_st <= WDPIC_SVC_ARMED;
			else if (wr_byte == `WDPIC_SVC_FIRE)
				svc_st <= WDPIC_SVC_IDLE;
			else
				svc_st <= WDPIC_SVC_FAULT;
		end else begin
			case (svc_st)
				WDPIC_SVC_FAULT: svc_st <= WDPIC_SVC_IDLE;
				WDPIC_SVC_ARMED: svc_st <= WDPIC_SVC_ARMED;
				WDPIC_SVC_IDLE:  svc_st <= WDPIC_SVC_IDLE;
				default:         svc_st <= WDPIC_SVC_IDLE;
			endcase
		end
	end

	// Time-out counter; a completed service restarts it from zero.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			wd_cnt <= 23'h00_0000;
		else if (wd_restart || wd_hit || wdog_rate_sel == 3'h0)
			wd_cnt <= 23'h00_0000;
		else if (p_tick)
			wd_cnt <= wd_cnt + 23'h00_0001;
	end

	// Reset request: one-cycle pulse on time-out or on a bad service value.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			wdog_reset_req <= 1'b0;
		else
			wdog_reset_req <= wd_hit || (svc_wr && wr_byte != `WDPIC_SVC_ARM
				&& wr_byte != `WDPIC_SVC_FIRE);
	end

	// ----------------------------------------------------------------
	// Clock-loss monitor
	// ----------------------------------------------------------------

	wdpic_sync3 u_mon_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.d       (mon_clk_pin),
		.q       (mon_lvl)
	);

	// Edges are judged on the filtered level only, never on the raw stages.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			mon_lvl_d <= 1'b0;
		else
			mon_lvl_d <= mon_lvl;
	end

	// The window is the longest one, so a merely slow clock does not trip it.
	assign cm_fail = clk_loss_mon_en && (cm_cnt == 12'(`WDPIC_CM_CYCLES - 1) || stop_mode);

	// Cycles since the last monitored edge, held at zero while disabled.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			cm_cnt <= 12'h000;
		else if (!clk_loss_mon_en || mon_lvl != mon_lvl_d || cm_fail)
			cm_cnt <= 12'h000;
		else
			cm_cnt <= cm_cnt + 12'h001;
	end

	// Registered reset request; one cycle on a window time-out, held for as long as stop mode lasts.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			clk_fail_reset_req <= 1'b0;
		else
			clk_fail_reset_req <= cm_fail;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	sequence s_arm;
		svc_wr && wr_byte == `WDPIC_SVC_ARM;
	endsequence

	sequence s_fire;
		svc_wr && wr_byte == `WDPIC_SVC_FIRE;
	endsequence

	chk_reset_state: assert property (
		$rose(resetn) |-> wdog_rate_sel == 3'h1 && !clk_loss_mon_en && !periodic_flag
			&& !periodic_irq_en && periodic_rate_sel == 3'h0 && stop_exit_delay)
		else $error("Reset state wrong.");

	chk_irq_follows: assert property (
		periodic_flag && periodic_irq_en |-> periodic_irq ##1 (periodic_irq || !periodic_flag
			|| !periodic_irq_en))
		else $error("Interrupt request not following flag.");

	chk_bad_service: assert property (
		svc_wr && wr_byte != 8'h55 && wr_byte != 8'haa |=> wdog_reset_req)
		else $error("Bad service value did not reset.");

	chk_service_restart: assert property (
		s_arm ##1 (!svc_wr) [*2] ##1 s_fire |=> wd_cnt == 23'h00_0000)
		else $error("Service sequence did not restart watchdog.");

	chk_lone_fire: assert property (
		svc_st == WDPIC_SVC_IDLE && svc_wr && wr_byte == 8'haa && !wd_hit && p_tick
			&& wdog_rate_sel != 3'h0 |=> wd_cnt == $past(wd_cnt) + 23'h00_0001)
		else $error("Lone second step restarted watchdog.");

	chk_wdog_timeout: assert property (
		p_tick && wdog_rate_sel != 3'h0 && wd_cnt == wd_lim |=> wdog_reset_req
			##1 wd_cnt <= 23'h00_0001)
		else $error("Watchdog time-out missed.");

	chk_flag_sticky: assert property (
		periodic_flag && !(wr_go && wr_idx == 8'h15) |=> periodic_flag)
		else $error("Periodic flag dropped without clear.");

	chk_flag_clear: assert property (
		periodic_flag && wr_go && wr_idx == 8'h15 && wr_byte[7] && !pic_hit |=> !periodic_flag)
		else $error("Periodic flag not cleared.");

	chk_halt_freeze: assert property (
		(wait_mode && wait_halt_bit || debug_mode && debug_halt_bit)[*3]
			|-> $stable(pic_cnt) && !p_tick)
		else $error("Counters ran while halted.");

	chk_rate_off: assert property (
		periodic_rate_sel == 3'h0 && !(wr_go && wr_idx == 8'h15) |=> $stable(periodic_flag))
		else $error("Periodic flag changed while off.");

	chk_monitor_off: assert property (
		!clk_loss_mon_en |=> !clk_fail_reset_req)
		else $error("Monitor reset while disabled.");

	chk_stop_fail: assert property (
		clk_loss_mon_en && stop_mode |=> clk_fail_reset_req)
		else $error("Stop with monitor enabled did not reset.");

	chk_halt_lock: assert property (
		halt_lock && !special_mode && wr_go && wr_idx == 8'h14
			|=> $stable(wait_halt_bit) && $stable(debug_halt_bit))
		else $error("Locked halt bit changed.");

endmodule

// >>> wdpic_tb.sv
// Self-checking testbench for the supervision block: registers, watchdog, periodic timer, monitor.
// Assumes the design files and wdpic_regs.svh are compiled ahead of it.
`include "wdpic_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	localparam int          TRIM = 10;
	localparam logic [31:0] A_PC = 32'(`WDPIC_IDX_PIC_CTRL) * 4;
	localparam logic [31:0] A_PF = 32'(`WDPIC_IDX_PIC_FLAG) * 4;
	localparam logic [31:0] A_WC = 32'(`WDPIC_IDX_WD_CTRL) * 4;
	localparam logic [31:0] A_SV = 32'(`WDPIC_IDX_WD_SVC) * 4;
	localparam logic [31:0] A_IC = 32'(`WDPIC_IDX_INT_CTRL) * 4;
	logic        sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, mon_run = 0, mon_clk_pin = 0;
	logic        wait_mode = 0, debug_mode = 0, stop_mode = 0, special_mode = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, periodic_irq, wdog_reset_req, clk_fail_reset_req;
	logic        stop_exit_delay;
	wire         hready = hreadyout;
	int          miscompares = 0, num_checks = 0, wd_n = 0, cf_n = 0;

	wdpic_top #(.PCLK_DIV(2), .DIV_TRIM(TRIM)) wdpic_top_i (.sys_clk(sys_clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.wait_mode(wait_mode), .debug_mode(debug_mode), .stop_mode(stop_mode),
		.special_mode(special_mode), .mon_clk_pin(mon_clk_pin), .periodic_irq(periodic_irq),
		.wdog_reset_req(wdog_reset_req), .clk_fail_reset_req(clk_fail_reset_req),
		.stop_exit_delay(stop_exit_delay));

	// Clock, monitored pin toggling every ten cycles while running, and pulse counters.
	always #12.5 sys_clk = ~sys_clk;
	always begin
		repeat (10) @(posedge sys_clk);
		if (mon_run) mon_clk_pin <= ~mon_clk_pin;
	end
	always @(posedge sys_clk) begin
		if (wdog_reset_req === 1'b1) wd_n <= wd_n + 1;
		if (clk_fail_reset_req === 1'b1) cf_n <= cf_n + 1;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic rng(input int got, input int lo, input int hi, input string m);
		num_checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("ERROR at %0t: %s took %0d cycles, not %0d..%0d", $time, m, got, lo, hi);
		end
	endtask

	// Reset is held ten cycles; the mode pin is settled before release.
	task automatic rst(input logic sp);
		special_mode <= sp;
		resetn <= 0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1;
	endtask

	// One single AHB-Lite word transfer; the address phase holds until hready is seen high.
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [7:0] e, input string m);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e}, m);
	endtask

	// Counts cycles until a reset request pulse is counted, giving up at lim.
	task automatic wait_req(input bit cf, input int lim, output int n);
		int s;
		s = cf ? cf_n : wd_n;
		n = 0;
		while ((cf ? cf_n : wd_n) == s && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	task automatic service;
		wr(A_SV, `WDPIC_SVC_ARM);
		wr(A_SV, `WDPIC_SVC_FIRE);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		int n;
		rst(0);
		rdc(A_WC, 8'h01, "wdog ctrl reset");
		rdc(A_PC, 8'h00, "periodic ctrl reset");
		rdc(A_PF, 8'h00, "flag reset");
		rdc(A_IC, 8'h20, "int ctrl reset");
		chk(stop_exit_delay, 1'b1, "stop exit delay");
		chk(periodic_irq, 1'b0, "irq after reset");
		wr(32'h0, 8'hff);
		rdc(32'h0, 8'h00, "unmapped read");
		wait_req(0, 60, n);
		rng(n, 1, 59, "unserviced time-out");
		wr(A_PC, 8'h40);
		wr(A_PC, 8'hab);
		rdc(A_PC, 8'hc3, "halt bits write once");
		wr(A_WC, 8'h03);
		wr(A_WC, 8'h05);
		rdc(A_WC, 8'h03, "rate write once");
		wr(A_IC, 8'h00);
		wr(A_IC, 8'h20);
		rdc(A_IC, 8'h00, "delay write once");
		chk(hresp, 1'b0, "okay response");
		$display("test reset done");
	endtask

	task automatic t_service;
		int s, n;
		rst(0);
		s = wd_n;
		repeat (6) service();
		chk(32'(wd_n - s), 32'h0, "serviced watchdog reset");
		s = wd_n;
		repeat (4) wr(A_SV, `WDPIC_SVC_FIRE);
		chk(32'(wd_n - s), 32'h0, "lone second write reset");
		wait_req(0, 40, n);
		rng(n, 1, 10, "lone second write");
		$display("test service done");
	endtask

	task automatic t_rates;
		int e[7] = '{13, 15, 17, 19, 21, 22, 23};
		int n, p;
		rst(1);
		for (int c = 1; c <= 7; c++) begin
			wr(A_WC, 8'(c));
			service();
			p = 2 * (2 ** (e[c - 1] - TRIM));
			wait_req(0, p + 20, n);
			rng(n, p - 3, p + 5, "watchdog period");
		end
		service();
		wr(A_SV, 8'h12);
		wait_req(0, 8, n);
		rng(n, 0, 4, "bad service value");
		wr(A_WC, 8'h00);
		wait_req(0, 300, n);
		rng(n, 300, 300, "watchdog off");
		$display("test rates done");
	endtask

	task automatic t_halt;
		int n;
		rst(1);
		for (int i = 0; i < 3; i++) begin
			wr(A_PC, (i == 0) ? 8'h40 : (i == 1) ? 8'h20 : 8'h00);
			wait_mode <= (i != 1);
			debug_mode <= (i != 0);
			service();
			wait_req(0, 100, n);
			rng(n, (i == 2) ? 0 : 100, (i == 2) ? 40 : 100, "halted watchdog");
			wait_mode <= 0;
			debug_mode <= 0;
			wait_req(0, 40, n);
			rng(n, 0, 39, "released watchdog");
		end
		$display("test halt done");
	endtask

	task automatic t_periodic;
		int n;
		realtime t1;
		rst(1);
		wr(A_WC, 8'h00);
		for (int r = 0; r <= 7; r++) begin
			wr(A_PC, (r == 0) ? 8'h89 : 8'h80 | 8'(r));
			wr(A_PF, 8'h80);
			@(posedge sys_clk);
			n = 0;
			while (periodic_irq !== 1'b1 && n < 2000) begin
				@(posedge sys_clk);
				n++;
			end
			t1 = $realtime;
			wr(A_PF, 8'h80);
			@(posedge sys_clk);
			while (periodic_irq !== 1'b1 && n < 4000) begin
				@(posedge sys_clk);
				n++;
			end
			rng(int'(($realtime - t1) / 25), 2 ** (r + 3), 2 ** (r + 3), "periodic rate");
		end
		wr(A_PF, 8'h00);
		rdc(A_PF, 8'h80, "write zero keeps flag");
		wr(A_PC, 8'h07);
		@(negedge sys_clk);
		chk(periodic_irq, 1'b0, "masked request");
		rdc(A_PF, 8'h80, "flag stays set");
		wr(A_PC, 8'h80);
		wr(A_PF, 8'h80);
		repeat (300) @(posedge sys_clk);
		chk(periodic_irq, 1'b0, "rate off request");
		rdc(A_PF, 8'h00, "rate off flag");
		$display("test periodic done");
	endtask

	task automatic t_monitor;
		int n;
		rst(1);
		wr(A_WC, 8'h00);
		wait_req(1, 900, n);
		rng(n, 900, 900, "monitor disabled");
		mon_run <= 1;
		wr(A_WC, 8'h80);
		rdc(A_WC, 8'h80, "monitor enable bit");
		wait_req(1, 1000, n);
		rng(n, 1000, 1000, "running clock");
		mon_run <= 0;
		wait_req(1, 1000, n);
		rng(n, 780, 815, "stopped clock");
		mon_run <= 1;
		repeat (40) @(posedge sys_clk);
		stop_mode <= 1;
		wait_req(1, 8, n);
		rng(n, 0, 4, "stop instruction");
		stop_mode <= 0;
		$display("test monitor done");
	endtask

	// ----------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// The tests need about 40000 cycles; a hang is cut off well beyond that.
	initial begin
		#(25 * 90000);
		miscompares++;
		$display("ERROR at %0t: run timed out", $time);
		test_done();
	end

	initial begin
		t_reset();
		t_service();
		t_rates();
		t_halt();
		t_periodic();
		t_monitor();
		test_done();
	end
endmodule
